// [include/rtsw_map.svh]
// Purpose: Offsets, reset values, bit positions and timing for RT status regs
// Assumes: 200 MHz core clock
// Notes:   Summary of operation follows
`ifndef RTSW_MAP_SVH
`define RTSW_MAP_SVH
// ==========================================
// Register map
`define RTSW_ADDR_STATUS    16'h000e
`define RTSW_ADDR_SELFTEST  16'h000f
`define RTSW_RST_STATUS     16'h0000
`define RTSW_RST_SELFTEST   16'h0000
`define RTSW_STATUS_LOW_W   11
// ==========================================
// Self-test word bit positions
`define RTSW_B_TX_TMO       15
`define RTSW_B_TX_SD_A      10
`define RTSW_B_TERMINAL_FLAG_INHIBITED        9
`define RTSW_B_SELFTEST     8
// Bits below this one are per-message flags
`define RTSW_MSG_BITS       8
// ==========================================
// Timing
`define RTSW_CLK_PERIOD_PS  5000
`define RTSW_TX_TMO_PS      668000000
`define RTSW_RTRT_T0_PS     18500000
`define RTSW_RTRT_T1_PS     22500000
`define RTSW_RTRT_T2_PS     50500000
`define RTSW_RTRT_T3_PS     130000000
`define RTSW_CNT_W          18
`endif

// [include/rtsw_pkg.sv]
// Purpose: Types for the RT status and self-test register block
// Assumes: Nothing beyond the map header
// Notes:   Flag groups travel as packed structs
package rtsw_pkg;
  // ==========================================
  // Live status sources, order matches status bits 10..0
  typedef struct packed {
    logic msg_error;
    logic instrumentation;
    logic service_request;
    logic [2:0] reserved;
    logic bcast_received;
    logic busy;
    logic subsystem_flag;
    logic bus_ctrl_accept;
    logic terminal_flag;
  } rtsw_status_t;

  // Per-message error events from the decoder and protocol logic
  typedef struct packed {
    logic word_count_high;
    logic word_count_low;
    logic wrong_sync_flag;
    logic invalid_word_flag;
    logic rt_to_rt_gap_sync_addr_error;
    logic rt_to_rt_cmd_word_error;
    logic rx_cmd_word_error;
  } rtsw_msg_err_t;
endpackage

// [verilog/rtsw_regs.sv]
// Purpose: RT status word and self-test word registers with host read port
// Assumes: All inputs synchronous to i_core_clk; event inputs are pulses
// Notes:   Read data appears one clock after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "rtsw_map.svh"

module rtsw_regs
  import rtsw_pkg::*;
#(
  parameter int TX_TMO_CYC =
    (`RTSW_TX_TMO_PS + `RTSW_CLK_PERIOD_PS - 1) / `RTSW_CLK_PERIOD_PS,
  parameter int RTRT_T0_CYC =
    (`RTSW_RTRT_T0_PS + `RTSW_CLK_PERIOD_PS - 1) / `RTSW_CLK_PERIOD_PS,
  parameter int RTRT_T1_CYC =
    (`RTSW_RTRT_T1_PS + `RTSW_CLK_PERIOD_PS - 1) / `RTSW_CLK_PERIOD_PS,
  parameter int RTRT_T2_CYC =
    (`RTSW_RTRT_T2_PS + `RTSW_CLK_PERIOD_PS - 1) / `RTSW_CLK_PERIOD_PS,
  parameter int RTRT_T3_CYC =
    (`RTSW_RTRT_T3_PS + `RTSW_CLK_PERIOD_PS - 1) / `RTSW_CLK_PERIOD_PS
)
(
  input  wire logic          i_core_clk,
  input  wire logic          i_rst,
  // Host read port
  input  wire logic [15:0]   i_host_addr,
  input  wire logic          i_host_rd,
  output logic [15:0]        o_host_rdata,
  output logic               o_host_rvalid,
  output logic               o_host_hit,
  // Status word sources
  input  wire rtsw_status_t  i_status_live,
  input  wire logic          i_alt_status_en,
  input  wire logic [10:0]   i_alt_status_word,
  // Transmitter and bus events
  input  wire logic          i_tx_active,
  input  wire logic          i_loopback_fail_bus_a,
  input  wire logic          i_loopback_fail_bus_b,
  input  wire logic          i_transparent_handshake_fail,
  input  wire logic          i_tx_shutdown_cmd,
  input  wire logic          i_tx_override_cmd,
  input  wire logic          i_cmd_on_bus_b,
  input  wire logic          i_inhibit_tflag_cmd,
  input  wire logic          i_override_tflag_cmd,
  input  wire logic          i_selftest_fail,
  // Message framing and errors
  input  wire logic          i_msg_start,
  input  wire rtsw_msg_err_t i_msg_err,
  input  wire logic          i_rtrt_wait,
  input  wire logic [1:0]    i_rtrt_tmo_sel,
  // Transmit self-test word mode command
  input  wire logic          i_tx_bit_word_cmd,
  output logic [15:0]        o_bit_tx_word,
  output logic               o_bit_tx_valid,
  // Transmitter disables for bus A and bus B
  output logic               o_tx_disable_bus_a,
  output logic               o_tx_disable_bus_b
);

  // ==========================================
  // Declarations
  logic [15:0]            status_q;
  logic [15:0]            status_d;
  logic [15:0]            selftest_q;
  logic [15:0]            selftest_d;
  logic [15:0]            set_vec;
  logic [15:0]            clr_vec;
  logic [`RTSW_CNT_W-1:0] tx_cnt_q;
  logic [`RTSW_CNT_W-1:0] tx_cnt_d;
  logic [`RTSW_CNT_W-1:0] rtrt_cnt_q;
  logic [`RTSW_CNT_W-1:0] rtrt_cnt_d;
  logic [`RTSW_CNT_W-1:0] rtrt_limit;
  logic                   tx_tmo_hit;
  logic                   rtrt_tmo_hit;
  logic                   rtrt_done_q;
  logic                   rtrt_done_d;
  logic                   tx_dis_a_q;
  logic                   tx_dis_b_q;
  logic                   shut_from_a;
  logic                   shut_from_b;
  logic                   tflag_live;
  logic [10:0]            status_low;
  logic                   sel_status;
  logic                   sel_selftest;
  logic [15:0]            rd_mux;
  logic [15:0]            rdata_q;
  logic                   rvalid_q;
  logic                   hit_q;
  logic [15:0]            bit_tx_q;
  logic                   bit_tx_v_q;
  logic                   inhibit_q;

  // Counter limits cast once so compares stay width clean
  localparam logic [`RTSW_CNT_W-1:0] TX_LIM = `RTSW_CNT_W'(TX_TMO_CYC);
  localparam logic [`RTSW_CNT_W-1:0] RT_L0  = `RTSW_CNT_W'(RTRT_T0_CYC);
  localparam logic [`RTSW_CNT_W-1:0] RT_L1  = `RTSW_CNT_W'(RTRT_T1_CYC);
  localparam logic [`RTSW_CNT_W-1:0] RT_L2  = `RTSW_CNT_W'(RTRT_T2_CYC);
  localparam logic [`RTSW_CNT_W-1:0] RT_L3  = `RTSW_CNT_W'(RTRT_T3_CYC);

  // ==========================================
  // Status word
  // Live terminal flag is forced low while the inhibit mode command holds; alternate word bit 0 is not masked
  assign tflag_live = i_status_live.terminal_flag & ~inhibit_q;

  // Live sources mapped onto bits 10..0; reserved bits stay zero unless the alternate word is selected
  // The reserved source inputs are dropped here so a stray driver cannot light them
  assign status_low = i_alt_status_en ? i_alt_status_word :
    {i_status_live.msg_error,
     i_status_live.instrumentation,
     i_status_live.service_request,
     3'h0,
     i_status_live.bcast_received,
     i_status_live.busy,
     i_status_live.subsystem_flag,
     i_status_live.bus_ctrl_accept,
     tflag_live};

  // Upper five bits are hard zero
  assign status_d = {5'h00, status_low};

  // ==========================================
  // Transmitter watchdog
  // Counts while one transmission is on the bus; saturates at the limit
  // The count restarts whenever the transmitter drops, so back-to-back
  // replies are each timed on their own
  assign tx_tmo_hit = i_tx_active && (tx_cnt_q == TX_LIM - 1'b1);
  assign tx_cnt_d   = !i_tx_active        ? '0 :
                      (tx_cnt_q == TX_LIM) ? tx_cnt_q :
                      tx_cnt_q + 1'b1;

  // ==========================================
  // RT-to-RT response timer
  // Limit follows the two-bit timeout selection
  assign rtrt_limit = (i_rtrt_tmo_sel == 2'h0) ? RT_L0 :
                      (i_rtrt_tmo_sel == 2'h1) ? RT_L1 :
                      (i_rtrt_tmo_sel == 2'h2) ? RT_L2 :
                      RT_L3;

  // Fires once when the wait runs past the selected limit; the >= compare keeps
  // a selection lowered mid-wait below the running count from being missed
  assign rtrt_tmo_hit = i_rtrt_wait && !rtrt_done_q && (rtrt_cnt_q >= rtrt_limit);
  assign rtrt_cnt_d   = !i_rtrt_wait                   ? '0 :
                        (rtrt_tmo_hit || rtrt_done_q) ? rtrt_cnt_q :
                        rtrt_cnt_q + 1'b1;
  assign rtrt_done_d  = i_rtrt_wait && (rtrt_done_q || rtrt_tmo_hit);

  // ==========================================
  // Transmitter shutdown
  // A command on one bus shuts the other, inactive bus
  // The bus qualifier is taken with the command itself, not held afterwards
  assign shut_from_a = i_tx_shutdown_cmd & ~i_cmd_on_bus_b;
  assign shut_from_b = i_tx_shutdown_cmd &  i_cmd_on_bus_b;

  // ==========================================
  // Self-test word set and clear vectors
  assign set_vec = {tx_tmo_hit,
                    i_loopback_fail_bus_b,
                    i_loopback_fail_bus_a,
                    i_transparent_handshake_fail,
                    shut_from_a,
                    shut_from_b,
                    i_inhibit_tflag_cmd,
                    i_selftest_fail,
                    i_msg_err.word_count_high,
                    i_msg_err.word_count_low,
                    i_msg_err.wrong_sync_flag,
                    i_msg_err.invalid_word_flag,
                    i_msg_err.rt_to_rt_gap_sync_addr_error,
                    rtrt_tmo_hit,
                    i_msg_err.rt_to_rt_cmd_word_error,
                    i_msg_err.rx_cmd_word_error};

  // Per-message flags are refreshed at each message start; the rest are sticky
  // so a one-off fault is never lost between host polls
  assign clr_vec = {{(16 - `RTSW_MSG_BITS){1'b0}},
                    {`RTSW_MSG_BITS{i_msg_start}}};

  // Set wins over clear so an error in the first cycle survives
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_flag
      assign selftest_d[g] = set_vec[g] | (selftest_q[g] & ~clr_vec[g]);
    end
  endgenerate

  // ==========================================
  // Host read decode
  assign sel_status   = (i_host_addr == `RTSW_ADDR_STATUS);
  assign sel_selftest = (i_host_addr == `RTSW_ADDR_SELFTEST);
  // Both registers are read-only; other addresses read as zero
  assign rd_mux = sel_status   ? status_q :
                  sel_selftest ? selftest_q :
                  16'h0000;

  // ==========================================
  // Status and self-test registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      status_q   <= `RTSW_RST_STATUS;
      selftest_q <= `RTSW_RST_SELFTEST;
    end
    else
    begin
      status_q   <= status_d;
      selftest_q <= selftest_d;
    end
  end

  // Timer counters
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      tx_cnt_q    <= '0;
      rtrt_cnt_q  <= '0;
      rtrt_done_q <= 1'b0;
    end
    else
    begin
      tx_cnt_q    <= tx_cnt_d;
      rtrt_cnt_q  <= rtrt_cnt_d;
      rtrt_done_q <= rtrt_done_d;
    end
  end

  // Transmitter disables and terminal flag inhibit, cleared by override commands
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      tx_dis_a_q <= 1'b0;
      tx_dis_b_q <= 1'b0;
      inhibit_q  <= 1'b0;
    end
    else
    begin
      if (shut_from_a)
        tx_dis_b_q <= 1'b1;
      else if (i_tx_override_cmd)
        tx_dis_b_q <= 1'b0;
      if (shut_from_b)
        tx_dis_a_q <= 1'b1;
      else if (i_tx_override_cmd)
        tx_dis_a_q <= 1'b0;
      if (i_inhibit_tflag_cmd)
        inhibit_q <= 1'b1;
      else if (i_override_tflag_cmd)
        inhibit_q <= 1'b0;
    end
  end

  // Host read data, one cycle after the strobe
  // Data holds between reads so a slow host may still pick it up late
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
      hit_q    <= 1'b0;
    end
    else
    begin
      rvalid_q <= i_host_rd;
      if (i_host_rd)
      begin
        rdata_q <= rd_mux;
        hit_q   <= sel_status | sel_selftest;
      end
    end
  end

  // Self-test word snapshot for the bus transmitter
  // A flag set in the command cycle itself goes out with the next request
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      bit_tx_q   <= 16'h0000;
      bit_tx_v_q <= 1'b0;
    end
    else
    begin
      bit_tx_v_q <= i_tx_bit_word_cmd;
      if (i_tx_bit_word_cmd)
        bit_tx_q <= selftest_q;
    end
  end

  // ==========================================
  // Outputs
  assign o_host_rdata       = rdata_q;
  assign o_host_rvalid      = rvalid_q;
  assign o_host_hit         = hit_q;
  assign o_bit_tx_word      = bit_tx_q;
  assign o_bit_tx_valid     = bit_tx_v_q;
  assign o_tx_disable_bus_a = tx_dis_a_q;
  assign o_tx_disable_bus_b = tx_dis_b_q;

endmodule

`default_nettype wire

// [test/rtsw_regs_properties.sv]
// Purpose: Port-level assertions for the status and self-test registers
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Read and command answers are fixed at one cycle
`timescale 1ns/1ps
`default_nettype none
module rtsw_regs_properties
(
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [15:0] i_host_addr,
  input wire logic        i_host_rd,
  input wire logic [15:0] o_host_rdata,
  input wire logic        o_host_rvalid,
  input wire logic        o_host_hit,
  input wire logic        i_alt_status_en,
  input wire logic [10:0] i_alt_status_word,
  input wire logic        i_loopback_fail_bus_a,
  input wire logic        i_tx_shutdown_cmd,
  input wire logic        i_cmd_on_bus_b,
  input wire logic        i_tx_bit_word_cmd,
  input wire logic        o_bit_tx_valid,
  input wire logic        o_tx_disable_bus_a,
  input wire logic        o_tx_disable_bus_b
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ==========================================
  // Address decode for the two mapped words
  wire rd_stat = i_host_rd && (i_host_addr == 16'h000e);
  wire rd_test = i_host_rd && (i_host_addr == 16'h000f);
  chk_read_latency: assert property (i_host_rd |=> o_host_rvalid)
    else $error("read not answered one cycle later");
  chk_read_idle: assert property (!i_host_rd |=> !o_host_rvalid)
    else $error("answer without a read");
  chk_status_upper: assert property (rd_stat |=> o_host_hit && o_host_rdata[15:11] == 5'h00)
    else $error("status upper bits not zero");
  chk_unmapped_zero: assert property (i_host_rd && i_host_addr[15:1] != 15'h0007
    |=> !o_host_hit && o_host_rdata == 16'h0000)
    else $error("unmapped read not empty");
  // Alternate word must win over live sources once it has been steady for a cycle
  chk_alt_status: assert property (rd_stat && i_alt_status_en && $past(i_alt_status_en)
    && $stable(i_alt_status_word) |=> o_host_rdata == {5'h00, $past(i_alt_status_word)})
    else $error("alternate status word not shown");
  // The bench reads two cycles after the event pulse
  chk_loopback_sticky: assert property (i_loopback_fail_bus_a ##2 rd_test |=> o_host_rdata[13])
    else $error("loopback flag missing");
  chk_bit_tx_pulse: assert property (i_tx_bit_word_cmd ##1 !i_tx_bit_word_cmd
    |-> o_bit_tx_valid ##1 !o_bit_tx_valid)
    else $error("self-test word not sent as one pulse");
  chk_shutdown_bus_b: assert property (i_tx_shutdown_cmd && !i_cmd_on_bus_b |=> o_tx_disable_bus_b)
    else $error("bus B transmitter not disabled");
  chk_shutdown_bus_a: assert property (i_tx_shutdown_cmd && i_cmd_on_bus_b |=> o_tx_disable_bus_a)
    else $error("bus A transmitter not disabled");
endmodule
`default_nettype wire

// [test/rtsw_bc_model.sv]
// Purpose: Bus controller stand-in that asks for the self-test word
// Assumes: Reply comes exactly one cycle after the command edge
// Notes:   Only the mode-command path is modelled
`timescale 1ns/1ps
`default_nettype none
module rtsw_bc_model
(
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_bit_word,
  input  wire logic        i_bit_valid,
  output logic             o_bit_cmd
);
  initial o_bit_cmd = 1'b0;
  // One command pulse, then the reply is sampled while it stands
  task automatic fetch(output logic [15:0] word, output logic ok);
    @(negedge i_core_clk);
    o_bit_cmd = 1'b1;
    @(negedge i_core_clk);
    o_bit_cmd = 1'b0;
    ok = (i_bit_valid === 1'b1);
    word = i_bit_word;
  endtask
endmodule
`default_nettype wire

// [test/test_rtsw_regs.sv]
// Purpose: Directed bench for the status and self-test registers
// Assumes: Short timeout counts set through parameters
// Notes:   Inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module test_rtsw_regs import rtsw_pkg::*;;
  localparam int TMO = 20;
  localparam int LIM [4] = '{5, 6, 8, 10};
  logic i_core_clk = 1'b0, i_rst = 1'b1, host_rd = 1'b0, rvalid, hit, alt_en = 1'b0, tx_active = 1'b0;
  logic msg_start = 1'b0, rtrt_wait = 1'b0, bit_valid, dis_a, dis_b;
  logic [15:0] host_addr = 16'h0000, rdata, bit_word, hi;
  logic [10:0] live = 11'h000, alt_word = 11'h000;
  logic [8:0] ev = 9'h000;
  logic [1:0] tmo_sel = 2'h0;
  rtsw_msg_err_t msg_err = '0;
  wire logic bit_cmd;
  int num_errors = 0, tests_run = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  rtsw_regs #(.TX_TMO_CYC(TMO), .RTRT_T0_CYC(LIM[0]), .RTRT_T1_CYC(LIM[1]), .RTRT_T2_CYC(LIM[2]),
    .RTRT_T3_CYC(LIM[3])) dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_host_addr(host_addr),
    .i_host_rd(host_rd), .o_host_rdata(rdata), .o_host_rvalid(rvalid), .o_host_hit(hit),
    .i_status_live(rtsw_status_t'(live)), .i_alt_status_en(alt_en), .i_alt_status_word(alt_word),
    .i_tx_active(tx_active), .i_loopback_fail_bus_b(ev[0]), .i_loopback_fail_bus_a(ev[1]),
    .i_transparent_handshake_fail(ev[2]), .i_tx_shutdown_cmd(ev[3] | ev[4]), .i_cmd_on_bus_b(ev[4]),
    .i_inhibit_tflag_cmd(ev[5]), .i_selftest_fail(ev[6]), .i_tx_override_cmd(ev[7]),
    .i_override_tflag_cmd(ev[8]), .i_msg_start(msg_start), .i_msg_err(msg_err), .i_rtrt_wait(rtrt_wait),
    .i_rtrt_tmo_sel(tmo_sel), .i_tx_bit_word_cmd(bit_cmd), .o_bit_tx_word(bit_word),
    .o_bit_tx_valid(bit_valid), .o_tx_disable_bus_a(dis_a), .o_tx_disable_bus_b(dis_b));
  rtsw_bc_model bc_u (.i_core_clk(i_core_clk), .i_bit_word(bit_word), .i_bit_valid(bit_valid),
    .o_bit_cmd(bit_cmd));
  // ==========================================
  // Shared helpers
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // Answer is fixed one cycle after the strobe, so it is judged at the next falling edge
  task automatic rd(logic [15:0] a, logic [15:0] exp, string name);
    @(negedge i_core_clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge i_core_clk);
    host_rd = 1'b0;
    check({name, " flags"}, {14'h0000, 1'b1, a[15:1] == 15'h0007}, {14'h0000, rvalid, hit});
    check(name, exp, rdata);
  endtask
  task automatic pulse_ev(logic [8:0] v);
    @(negedge i_core_clk);
    ev = v;
    @(negedge i_core_clk);
    ev = 9'h000;
  endtask
  task automatic new_msg();
    @(negedge i_core_clk);
    msg_start = 1'b1;
    @(negedge i_core_clk);
    msg_start = 1'b0;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(16'h000e, 16'h0000, "status reset");
    rd(16'h000f, 16'h0000, "selftest reset");
    rd(16'h0010, 16'h0000, "unmapped");
    $display("test reset done");
  endtask
  // Walking one over the sources; reserved positions must stay dark
  task automatic t_status();
    for (int i = 0; i < 11; i++)
    begin
      live = 11'h001 << i;
      cyc(2);
      rd(16'h000e, (i > 4 && i < 8) ? 16'h0000 : 16'h0001 << i, "status bit");
    end
    live = 11'h7ff;
    alt_en = 1'b1;
    alt_word = 11'h0e5;
    cyc(2);
    rd(16'h000e, 16'h00e5, "alt status");
    alt_word = 11'h51a;
    cyc(2);
    rd(16'h000e, 16'h051a, "alt status");
    alt_en = 1'b0;
    $display("test status done");
  endtask
  task automatic t_events();
    hi = 16'h0000;
    for (int i = 0; i < 7; i++)
    begin
      pulse_ev(9'h001 << i);
      hi = hi | (16'h4000 >> i);
      rd(16'h000f, hi, "sticky flag");
    end
    check("disables", 16'h0003, {14'h0000, dis_a, dis_b});
    pulse_ev(9'h080);
    check("disables cleared", 16'h0000, {14'h0000, dis_a, dis_b});
    // Inhibit still holds, so a live terminal flag stays dark until overridden
    live = 11'h001;
    cyc(2);
    rd(16'h000e, 16'h0000, "flag masked");
    pulse_ev(9'h100);
    cyc(1);
    rd(16'h000e, 16'h0001, "flag unmasked");
    rd(16'h000f, hi, "inhibit kept");
    live = 11'h000;
    $display("test events done");
  endtask
  task automatic t_msg();
    for (int j = 0; j < 7; j++)
    begin
      new_msg();
      @(negedge i_core_clk);
      msg_err = rtsw_msg_err_t'(7'h01 << j);
      @(negedge i_core_clk);
      msg_err = '0;
      rd(16'h000f, hi | (16'h0001 << (j < 2 ? j : j + 1)), "message flag");
      rd(16'h000f, hi | (16'h0001 << (j < 2 ? j : j + 1)), "message hold");
    end
    new_msg();
    rd(16'h000f, hi, "message clear");
    $display("test message done");
  endtask
  // Each select is held for exactly its own limit, then two cycles past it
  task automatic t_rtrt();
    for (int s = 0; s < 4; s++)
    begin
      tmo_sel = 2'(s);
      new_msg();
      rtrt_wait = 1'b1;
      cyc(LIM[s]);
      rtrt_wait = 1'b0;
      rd(16'h000f, hi, "rtrt early");
      new_msg();
      rtrt_wait = 1'b1;
      cyc(LIM[s] + 2);
      rtrt_wait = 1'b0;
      rd(16'h000f, hi | 16'h0004, "rtrt late");
    end
    new_msg();
    $display("test rtrt done");
  endtask
  task automatic t_tmo_bit();
    logic [15:0] w;
    logic ok;
    tx_active = 1'b1;
    cyc(TMO - 2);
    rd(16'h000f, hi, "tx early");
    cyc(4);
    tx_active = 1'b0;
    hi = hi | 16'h8000;
    rd(16'h000f, hi, "tx timeout");
    bc_u.fetch(w, ok);
    check("bit valid", 16'h0001, {15'h0000, ok});
    check("bit word", hi, w);
    $display("test timeout and transmit done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (5) @(negedge i_core_clk);
    i_rst = 1'b0;
    t_reset();
    t_status();
    t_events();
    t_msg();
    t_rtrt();
    t_tmo_bit();
    finish_test();
  end
endmodule
bind rtsw_regs rtsw_regs_properties chk_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_host_addr(i_host_addr),
  .i_host_rd(i_host_rd), .o_host_rdata(o_host_rdata), .o_host_rvalid(o_host_rvalid), .o_host_hit(o_host_hit),
  .i_alt_status_en(i_alt_status_en), .i_alt_status_word(i_alt_status_word),
  .i_loopback_fail_bus_a(i_loopback_fail_bus_a), .i_tx_shutdown_cmd(i_tx_shutdown_cmd),
  .i_cmd_on_bus_b(i_cmd_on_bus_b), .i_tx_bit_word_cmd(i_tx_bit_word_cmd), .o_bit_tx_valid(o_bit_tx_valid),
  .o_tx_disable_bus_a(o_tx_disable_bus_a), .o_tx_disable_bus_b(o_tx_disable_bus_b));
`default_nettype wire
